// ==== logic/limit_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "limit_status_flags_cfg.svh"

module limit_status_flags
	import limit_status_flags_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Conversion engine results
	input wire logic conv_valid_i,
	input wire conv_result_t conv_i,
	input wire logic cycle_done_i,
	// Channel configuration and override limits
	input wire logic remote_temp_two_volt_mode_i,
	input wire logic [7:0] thermal_override_limit_one_i,
	input wire logic [7:0] thermal_override_limit_two_i,
	// Register port
	input wire reg_req_t reg_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_hit_o,
	// Override state
	output logic thermal_override_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// One-hot flag position: bits 7..0 first register, 15..8 second
	function automatic logic [15:0] flag_of(input logic [4:0] chan, input logic volt_mode);
		logic [15:0] m;
		m = 16'h0000;
		if (chan < `CH_REMOTE_TEMP_ONE) begin
			m = 16'h0100 << chan[2:0];
		end else if (chan == `CH_REMOTE_TEMP_ONE) begin
			m = 16'h0001;
		end else if (chan == `CH_REMOTE_TEMP_TWO) begin
			m = volt_mode ? 16'h0000 : 16'h0002;
		end else if (chan == `CH_ALT_ANALOG) begin
			m = volt_mode ? 16'h0002 : 16'h0000;
		end else if (chan <= `CH_LAST) begin
			m = 16'h0004 << (chan - `CH_STANDBY_RAIL);
		end
		return m;
	endfunction : flag_of

	// Release point, clamped so a very low limit cannot wrap
	function automatic logic [7:0] release_of(input logic [7:0] lim);
		logic signed [8:0] r;
		r = $signed({lim[7], lim}) - $signed({1'b0, `THERMAL_OVERRIDE_HYST_DEGC});
		return (r < -9'sd128) ? 8'h80 : r[7:0];
	endfunction : release_of

	// ----------------------------------------
	// Window comparison
	// ----------------------------------------

	logic out_win;
	logic is_temp;
	logic [15:0] hit_mask;

	assign is_temp = (conv_i.chan == `CH_REMOTE_TEMP_ONE) ||
		((conv_i.chan == `CH_REMOTE_TEMP_TWO) && !remote_temp_two_volt_mode_i);

	limit_window_check u_window (
		.value_i(conv_i.value),
		.high_limit_i(conv_i.high_limit),
		.low_limit_i(conv_i.low_limit),
		.signed_i(is_temp),
		.out_of_window_o(out_win)
	);

	assign hit_mask = (conv_valid_i && out_win) ?
		flag_of(conv_i.chan, remote_temp_two_volt_mode_i) : 16'h0000;

	// ----------------------------------------
	// Thermal override tracking
	// ----------------------------------------

	thermal_override_state_t thermal_override_q [2];
	logic [1:0] thermal_override_evt;
	logic [7:0] thermal_override_lim [2];
	logic [1:0] thermal_override_sample;

	assign thermal_override_lim[0] = thermal_override_limit_one_i;
	assign thermal_override_lim[1] = thermal_override_limit_two_i;
	assign thermal_override_sample[0] = conv_valid_i && (conv_i.chan == `CH_REMOTE_TEMP_ONE);
	// Voltage mode has no thermal meaning on this channel
	assign thermal_override_sample[1] = conv_valid_i && (conv_i.chan == `CH_REMOTE_TEMP_TWO) &&
		!remote_temp_two_volt_mode_i;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			thermal_override_evt[i] = 1'b0;
			if (thermal_override_sample[i]) begin
				case (thermal_override_q[i])
					thermal_override_idle: begin
						thermal_override_evt[i] = $signed(conv_i.value) > $signed(thermal_override_lim[i]);
					end
					thermal_override_engaged: begin
						thermal_override_evt[i] = $signed(conv_i.value) <= $signed(release_of(thermal_override_lim[i]));
					end
					default: begin
						thermal_override_evt[i] = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (!resetn_i) begin
				thermal_override_q[i] <= thermal_override_idle;
			end else if (thermal_override_evt[i]) begin
				thermal_override_q[i] <= (thermal_override_q[i] == thermal_override_idle) ? thermal_override_engaged : thermal_override_idle;
			end
		end
	end

	assign thermal_override_o = (thermal_override_q[0] == thermal_override_engaged) || (thermal_override_q[1] == thermal_override_engaged);

	// ----------------------------------------
	// Accumulation over the running cycle
	// ----------------------------------------

	logic [15:0] acc_q;
	logic [1:0] evt_pend_q;
	logic [7:0] temp_supply_flags_q;
	logic [7:0] analog_input_flags_q;
	logic [15:0] next_flags;

	// Events on the boundary cycle go straight into the new flags
	assign next_flags = acc_q | hit_mask | {14'h0000, evt_pend_q | thermal_override_evt};

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || cycle_done_i) begin
			acc_q <= 16'h0000;
		end else begin
			acc_q <= acc_q | hit_mask;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || cycle_done_i) begin
			evt_pend_q <= 2'h0;
		end else begin
			evt_pend_q <= evt_pend_q | thermal_override_evt;
		end
	end

	// ----------------------------------------
	// Flag registers
	// ----------------------------------------

	// zero from reset; refreshed per cycle
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			temp_supply_flags_q <= `FLAGS_RESET;
			analog_input_flags_q <= `FLAGS_RESET;
		end else if (cycle_done_i) begin
			temp_supply_flags_q <= next_flags[7:0];
			analog_input_flags_q <= next_flags[15:8];
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------

	logic addr_hit;

	assign addr_hit = (reg_i.addr == `TEMP_SUPPLY_FLAGS_ADDR) ||
		(reg_i.addr == `ANALOG_INPUT_FLAGS_ADDR);
	assign reg_hit_o = addr_hit && (reg_i.rd || reg_i.wr);

	// writes are decoded but have no path into the flags
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_i.rd) begin
			case (reg_i.addr)
				`TEMP_SUPPLY_FLAGS_ADDR: reg_rdata_o <= temp_supply_flags_q;
				`ANALOG_INPUT_FLAGS_ADDR: reg_rdata_o <= analog_input_flags_q;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_one_engages;
		thermal_override_q[0] == thermal_override_idle ##1 thermal_override_q[0] == thermal_override_engaged;
	endsequence

	sequence s_one_releases;
		thermal_override_q[0] == thermal_override_engaged ##1 thermal_override_q[0] == thermal_override_idle;
	endsequence

	sequence s_two_changes;
		thermal_override_q[1] != $past(thermal_override_q[1]);
	endsequence

	a_reset_clears: assert property (disable iff (1'b0) !resetn_i |=>
		(temp_supply_flags_q == 8'h00 && analog_input_flags_q == 8'h00))
		else $error("flags not zero after reset");

	a_one_window_flag: assert property (conv_valid_i && out_win &&
		conv_i.chan == `CH_REMOTE_TEMP_ONE && cycle_done_i |=> temp_supply_flags_q[0])
		else $error("remote_temp_one window miss not flagged");

	// engage event reaches bit 0 by the next boundary
	a_one_engage_flag: assert property (s_one_engages |->
		$past(thermal_override_evt[0]) && (evt_pend_q[0] || temp_supply_flags_q[0]))
		else $error("engage on remote_temp_one not flagged");

	// release needs reading 5 below the limit
	a_one_release_flag: assert property (s_one_releases |->
		$past(thermal_override_evt[0]) && ($signed($past(conv_i.value)) <=
		$signed($past(thermal_override_limit_one_i)) - 5) && (evt_pend_q[0] || temp_supply_flags_q[0]))
		else $error("release on remote_temp_one wrong");

	// voltage mode routes alternate input to bit 1
	a_alt_routes_bit1: assert property (remote_temp_two_volt_mode_i && conv_valid_i &&
		out_win && conv_i.chan == `CH_ALT_ANALOG && cycle_done_i |=>
		temp_supply_flags_q[1])
		else $error("alternate input not flagged on bit 1");

	// every override change on remote_temp_two marks bit 1
	a_two_change_flag: assert property (s_two_changes |->
		(evt_pend_q[1] || temp_supply_flags_q[1]))
		else $error("remote_temp_two override change not flagged");

	// boundary loads the cycle's findings exactly
	a_boundary_load: assert property (cycle_done_i |=>
		{analog_input_flags_q, temp_supply_flags_q} == $past(next_flags))
		else $error("flags differ from cycle findings");

	// core supply miss lands on bit 5 only among rails
	a_core_bit5: assert property (conv_valid_i && out_win && conv_i.chan == `CH_CORE_SUPPLY
		&& cycle_done_i && acc_q == 16'h0000 && evt_pend_q == 2'h0 |=>
		temp_supply_flags_q == 8'h20 && analog_input_flags_q == 8'h00)
		else $error("core supply miss on wrong bit");

	// flags stand still between boundaries, writes included
	a_write_ignored: assert property (!cycle_done_i ##1 reg_i.wr |->
		$stable(temp_supply_flags_q) && $stable(analog_input_flags_q))
		else $error("flags moved without a boundary");

	// read of second register returns its flags
	a_read_second: assert property (reg_i.rd && reg_i.addr == `ANALOG_INPUT_FLAGS_ADDR |=>
		reg_rdata_o == $past(analog_input_flags_q))
		else $error("wrong data for second flag register");

endmodule : limit_status_flags

`default_nettype wire

// ==== logic/limit_window_check.sv ====
`timescale 1ns/1ps
`default_nettype none

module limit_window_check (
	// Reading and limits
	input wire logic [7:0] value_i,
	input wire logic [7:0] high_limit_i,
	input wire logic [7:0] low_limit_i,
	// Temperatures are twos complement, rails unsigned
	input wire logic signed_i,
	// Result
	output logic out_of_window_o
);

	always_comb begin
		if (signed_i) begin
			out_of_window_o = ($signed(value_i) > $signed(high_limit_i)) ||
				($signed(value_i) < $signed(low_limit_i));
		end else begin
			out_of_window_o = (value_i > high_limit_i) || (value_i < low_limit_i);
		end
	end

endmodule : limit_window_check

`default_nettype wire

// ==== shared/limit_status_flags_cfg.svh ====
// Notes on behaviour
// - Bit 0 of the first flag register is 1 when the previous cycle's remote_temp_one was outside its window.
// - Bit 0 is set once more when thermal_override engages on remote_temp_one exceeding its limit.
// - Bit 0 is set once more when thermal_override disengages on remote_temp_one falling 5 C below it.
// - Bit 1 flags remote_temp_two, or alternate_analog_input when that channel measures voltage.
// - Bit 1 is set once on thermal_override engage and once on disengage for remote_temp_two.
// - Bit 2 is 1 when the standby_rail reading of the previous cycle was outside its window.
// - Bit 3 is 1 when the 3.3 V main rail reading of the previous cycle was outside its window.
// - Bit 4 is 1 when the +5 V rail reading of the previous cycle was outside its window.
// - Bit 5 flags processor_core_supply and bit 6 flags the +12 V rail the same way.
// - Bit 7 is 1 when the -12 V rail reading of the previous cycle was outside its window.
// - Bits 0 to 7 of the second flag register flag general analog inputs 0 to 7 the same way.
// - Both flag registers read all zero from reset until a conversion cycle has been compared.
`ifndef LIMIT_STATUS_FLAGS_CFG_SVH
`define LIMIT_STATUS_FLAGS_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define TEMP_SUPPLY_FLAGS_ADDR 8'h20
`define ANALOG_INPUT_FLAGS_ADDR 8'h21
`define FLAGS_RESET 8'h00

// ----------------------------------------
// Channel codes, bit position in flag pair
// ----------------------------------------
`define CH_REMOTE_TEMP_ONE 5'h08
`define CH_REMOTE_TEMP_TWO 5'h09
`define CH_ALT_ANALOG 5'h0A
`define CH_STANDBY_RAIL 5'h0B
`define CH_MAIN_RAIL 5'h0C
`define CH_PLUS5_RAIL 5'h0D
`define CH_CORE_SUPPLY 5'h0E
`define CH_PLUS12_RAIL 5'h0F
`define CH_MINUS12_RAIL 5'h10
`define CH_LAST 5'h10

// ----------------------------------------
// Thermal override hysteresis, degrees C
// ----------------------------------------
`define THERMAL_OVERRIDE_HYST_DEGC 8'h05

`endif

// ==== shared/limit_status_flags_pkg.sv ====
`default_nettype none

package limit_status_flags_pkg;

	// One comparison result from the conversion engine
	typedef struct packed {
		logic [4:0] chan;
		logic [7:0] value;
		logic [7:0] high_limit;
		logic [7:0] low_limit;
	} conv_result_t;

	// Register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic {
		thermal_override_idle,
		thermal_override_engaged
	} thermal_override_state_t;

endpackage : limit_status_flags_pkg

`default_nettype wire

// ==== verif/smbus_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host reading the flag registers
// ----------------------------------------
module smbus_host_model
	import limit_status_flags_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Register port
	output var reg_req_t reg_o,
	input wire logic [7:0] rdata_i,
	input wire logic hit_i
);
	initial begin
		reg_o = '0;
	end

	// Idle bus shows inverted leftovers, never a stale copy
	task automatic release_bus(input logic [7:0] addr, input logic [7:0] data);
		reg_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
	endtask : release_bus

	task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic hit);
		@(negedge sys_clk_i);
		reg_o = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
		#1;
		hit = hit_i;
		@(negedge sys_clk_i);
		data = rdata_i;
		release_bus(addr, 8'h00);
	endtask : read

	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk_i);
		reg_o = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
		@(negedge sys_clk_i);
		release_bus(addr, data);
	endtask : write
endmodule : smbus_host_model

`default_nettype wire

// ==== verif/test_limit_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "limit_status_flags_cfg.svh"

module test_limit_status_flags
	import limit_status_flags_pkg::*;
;
	logic sys_clk_i, resetn_i, conv_valid_i, cycle_done_i, volt_mode;
	conv_result_t conv_i;
	logic [7:0] lim_one, lim_two, rdata, ev;
	reg_req_t reg_i;
	logic hit, ovr;
	int fails = 0;
	int total_checks = 0;

	limit_status_flags uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.conv_valid_i(conv_valid_i), .conv_i(conv_i), .cycle_done_i(cycle_done_i),
		.remote_temp_two_volt_mode_i(volt_mode), .thermal_override_limit_one_i(lim_one),
		.thermal_override_limit_two_i(lim_two), .reg_i(reg_i), .reg_rdata_o(rdata),
		.reg_hit_o(hit), .thermal_override_o(ovr));

	smbus_host_model host (.sys_clk_i(sys_clk_i), .reg_o(reg_i), .rdata_i(rdata),
		.hit_i(hit));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw 0x%0h, expected 0x%0h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic h;
		host.read(addr, d, h);
		check(d, exp);
		check({7'h00, h}, {7'h00, addr == 8'h20 || addr == 8'h21});
	endtask : rd_check

	// One result then the end-of-cycle pulse
	task automatic run_cycle(input logic [4:0] ch, input logic [7:0] v, hi, lo);
		@(negedge sys_clk_i);
		conv_valid_i = 1'b1;
		conv_i = '{chan: ch, value: v, high_limit: hi, low_limit: lo};
		@(negedge sys_clk_i);
		conv_valid_i = 1'b0;
		conv_i = ~conv_i;
		cycle_done_i = 1'b1;
		@(negedge sys_clk_i);
		cycle_done_i = 1'b0;
	endtask : run_cycle

	// Result on the boundary cycle itself, so set wins over the clear
	task automatic run_same(input logic [4:0] ch, input logic [7:0] v, hi, lo);
		@(negedge sys_clk_i);
		conv_valid_i = 1'b1;
		cycle_done_i = 1'b1;
		conv_i = '{chan: ch, value: v, high_limit: hi, low_limit: lo};
		@(negedge sys_clk_i);
		conv_valid_i = 1'b0;
		cycle_done_i = 1'b0;
		conv_i = ~conv_i;
	endtask : run_same

	// Engage, hold, boundary above release, release, quiet
	task automatic thermal_override_seq(input logic [4:0] ch, input logic [7:0] bitv);
		logic [7:0] vals [5] = '{8'h41, 8'h41, 8'h3C, 8'h3B, 8'h3B};
		for (int i = 0; i < 5; i++) begin
			run_cycle(ch, vals[i], 8'h7F, 8'h80);
			rd_check(`TEMP_SUPPLY_FLAGS_ADDR, (i == 0 || i == 3) ? bitv : 8'h00);
			check({7'h00, ovr}, {7'h00, i < 3});
		end
	endtask : thermal_override_seq

	task automatic print_verdict;
		$display("Checks: %0d, mismatches: %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	// Whole run is well under a thousand cycles
	initial begin
		#(25 * 4000);
		fails++;
		print_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		resetn_i = 1'b0;
		conv_valid_i = 1'b0;
		cycle_done_i = 1'b0;
		conv_i = '0;
		volt_mode = 1'b0;
		lim_one = 8'h7F;
		lim_two = 8'h7F;
		repeat (4) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, `FLAGS_RESET);
		rd_check(`ANALOG_INPUT_FLAGS_ADDR, `FLAGS_RESET);
		rd_check(8'h22, 8'h00);
		check({7'h00, ovr}, 8'h00);
		$display("Test reset done");
		// Above high, on high, below low, per channel
		for (int c = 0; c <= 16; c++) begin
			if (c < 8 || c > 10) begin
				ev = 8'h01 << (c < 8 ? c : c - 9);
				run_cycle(5'(c), 8'h81, 8'h80, 8'h10);
				rd_check(c < 8 ? 8'h21 : 8'h20, ev);
				run_cycle(5'(c), 8'h80, 8'h80, 8'h10);
				rd_check(c < 8 ? 8'h21 : 8'h20, 8'h00);
				run_cycle(5'(c), 8'h0F, 8'h80, 8'h10);
				rd_check(c < 8 ? 8'h21 : 8'h20, ev);
			end
		end
		$display("Test rails and inputs done");
		host.write(`TEMP_SUPPLY_FLAGS_ADDR, 8'hFF);
		host.write(`ANALOG_INPUT_FLAGS_ADDR, 8'hFF);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h80);
		rd_check(`ANALOG_INPUT_FLAGS_ADDR, 8'h00);
		$display("Test writes done");
		// Signed window: unsigned reading would flag this
		run_cycle(5'h08, 8'hF0, 8'h10, 8'hE0);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h00);
		run_cycle(5'h08, 8'hDF, 8'h10, 8'hE0);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h01);
		run_cycle(5'h0A, 8'hFF, 8'h80, 8'h10);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h00);
		run_cycle(5'h09, 8'h11, 8'h10, 8'hE0);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h02);
		volt_mode = 1'b1;
		run_cycle(5'h09, 8'h11, 8'h10, 8'hE0);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h00);
		run_cycle(5'h0A, 8'hFF, 8'h80, 8'h10);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h02);
		run_same(5'h0A, 8'h05, 8'h80, 8'h10);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h02);
		volt_mode = 1'b0;
		run_same(5'h08, 8'h20, 8'h10, 8'hE0);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h01);
		run_same(5'h0E, 8'h81, 8'h80, 8'h10);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h20);
		// Channel code past the last rail must not land anywhere
		run_same(5'h11, 8'hFF, 8'h80, 8'h10);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h00);
		rd_check(`ANALOG_INPUT_FLAGS_ADDR, 8'h00);
		$display("Test remote channels done");
		lim_one = 8'h40;
		lim_two = 8'h40;
		thermal_override_seq(5'h08, 8'h01);
		thermal_override_seq(5'h09, 8'h02);
		// Override events on the boundary cycle reach the new flags
		run_same(5'h08, 8'h41, 8'h7F, 8'h80);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h01);
		check({7'h00, ovr}, 8'h01);
		run_same(5'h08, 8'h3B, 8'h7F, 8'h80);
		rd_check(`TEMP_SUPPLY_FLAGS_ADDR, 8'h01);
		check({7'h00, ovr}, 8'h00);
		$display("Test override events done");
		print_verdict();
	end
endmodule : test_limit_status_flags

`default_nettype wire
